// >>> core/charger_cfg.svh
// timing, field and encoding constants for the charger sequencer
// assumes a 125 MHz system clock and word-aligned register access
`ifndef CHARGER_CFG_SVH
`define CHARGER_CFG_SVH

// clock and timing
`define CLK_KHZ        125000
`define PWM_KHZ        600
`define DUTY_MAX_PCT   97
`define PCT_FULL       100
`define POWERUP_MS     50
`define STEP_US        1600
`define US_PER_MS      1000
`define OVP_MS         30
`define BLINK_MS       250

// soft start
`define STEP_COUNT     4'h8
`define STEP_FIRST     4'h1
`define STEP_NONE      4'h0

// register byte offsets
`define REG_CONTROL    4'h0
`define REG_DUTY       4'h4
`define REG_STATUS     4'h8

// register reset values
`define CONTROL_RESET  1'h1
`define DUTY_RESET     8'h00

// regulation voltage in millivolts
`define VREG_1CELL_MV  14'h1068
`define VREG_2CELL_MV  14'h20D0
`define VREG_3CELL_MV  14'h3138

// sense gain divisors for fast charge and precharge
`define FAST_DIVISOR   7'h14
`define PRE_DIVISOR    7'h64

`endif

// >>> core/charger_control_sequencer.sv
// charger control, protection and buck gate sequencing
// assumes comparator flags already synchronous to sys_clk, one ahb master
`timescale 1ns/1ps
`default_nettype none
`include "charger_cfg.svh"

module charger_control_sequencer
   import charger_pkg::*;
#(
   parameter int POWERUP_CYCLES = `POWERUP_MS * `CLK_KHZ,
   parameter int STEP_CYCLES    = `STEP_US * `CLK_KHZ / `US_PER_MS,
   parameter int OVP_CYCLES     = `OVP_MS * `CLK_KHZ,
   parameter int BLINK_CYCLES   = `BLINK_MS * `CLK_KHZ,
   parameter int TIMER_W        = 26
)(
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic [1:0]  pack_series_select,
   input  wire logic        charge_rate_select,
   input  wire logic        setpoint_above_120mv,
   input  wire logic        setpoint_below_40mv,
   input  wire logic        supply_above_sense_neg,
   input  wire logic        undervoltage_lockout,
   input  wire logic        input_overvoltage,
   input  wire logic        regulators_ok,
   input  wire logic        regulator_overload,
   input  wire logic        die_overheat_trip,
   input  wire logic        die_below_130c,
   input  wire logic        thermistor_in_start_window,
   input  wire logic        thermistor_in_run_window,
   input  wire logic        bootstrap_below_4v,
   input  wire logic        sense_below_5mv,
   input  wire logic        sense_avg_below_1p25mv,
   input  wire logic        pack_below_2v,
   input  wire logic        sense_neg_below_2v,
   input  wire logic        high_side_overcurrent,
   input  wire logic        charge_over_160pct,
   input  wire logic        pack_above_102pct,
   output logic             high_side_gate,
   output logic             low_side_gate,
   output logic             charge_active,
   output logic             precharge_mode,
   output logic      [6:0]  current_divisor,
   output logic      [3:0]  current_step,
   output logic      [13:0] regulation_mv,
   output logic             short_current_limit,
   output logic             discharge_sink_enable,
   output logic             reference_enable,
   output logic             indicator_out,
   output logic             indicator_oe
);

   // ****************************************************************
   // constants and state
   // ****************************************************************
   localparam int         PWM_PERIOD = `CLK_KHZ / `PWM_KHZ;
   localparam logic [7:0] PWM_LAST   = 8'(PWM_PERIOD - 1);
   localparam logic [7:0] ON_MAX     =
      8'(PWM_PERIOD * `DUTY_MAX_PCT / `PCT_FULL);

   charge_state_type     state;
   charge_state_type     next_state;
   logic                 setpoint_en;
   logic                 die_hot;
   logic                 ts_fault;
   logic                 pu_done;
   logic [TIMER_W-1:0]   pu_cnt;
   logic [TIMER_W-1:0]   ovp_cnt;
   logic                 ovp_lat;
   logic [TIMER_W-1:0]   step_cnt;
   logic [TIMER_W-1:0]   blink_cnt;
   logic                 blink_phase;
   logic                 short_q;
   logic [7:0]           pwm_cnt;
   logic                 oc_hold;
   logic                 ls_block;
   logic                 refresh_q;
   logic                 ctrl_permit;
   logic [7:0]           duty;
   logic                 next_permit;
   logic [7:0]           next_duty;
   logic                 wr_pend;
   logic [3:0]           wr_addr;
   logic                 lock;
   logic                 allow;
   logic                 next_run;
   logic                 short_edge;
   logic                 wrap;
   logic [7:0]           duty_eff;
   logic                 next_hs;
   logic                 next_ls;
   logic                 next_refresh;
   logic                 sync_ok;
   logic                 addr_ok;
   logic [31:0]          status;
   logic [7:0]           hs_run;

   // ****************************************************************
   // enable conditions
   // ****************************************************************
   // lockout and idle
   assign lock = undervoltage_lockout || !supply_above_sense_neg;

   assign allow = setpoint_en && !setpoint_below_40mv && !lock &&
                  !input_overvoltage && pu_done && regulators_ok &&
                  !regulator_overload && !die_hot && !die_overheat_trip &&
                  !ts_fault && !ovp_lat && ctrl_permit;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         setpoint_en <= 1'b0;
      end else if (setpoint_above_120mv) begin
         setpoint_en <= 1'b1;
      end else if (setpoint_below_40mv) begin
         setpoint_en <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         die_hot <= 1'b0;
      end else if (die_overheat_trip) begin
         die_hot <= 1'b1;
      end else if (die_below_130c) begin
         die_hot <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ts_fault <= 1'b0;
      end else if (charge_active ? !thermistor_in_run_window
                                 : !thermistor_in_start_window) begin
         ts_fault <= 1'b1;
      end else if (thermistor_in_start_window) begin
         ts_fault <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pu_cnt  <= '0;
         pu_done <= 1'b0;
      end else if (undervoltage_lockout) begin
         pu_cnt  <= '0;
         pu_done <= 1'b0;
      end else if (!pu_done) begin
         pu_cnt  <= pu_cnt + 1'b1;
         pu_done <= (pu_cnt == TIMER_W'(POWERUP_CYCLES - 1));
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ovp_cnt <= '0;
         ovp_lat <= 1'b0;
      end else if (!pack_above_102pct) begin
         ovp_cnt <= '0;
         ovp_lat <= 1'b0;
      end else if (ovp_cnt == TIMER_W'(OVP_CYCLES)) begin
         ovp_lat <= 1'b1;
      end else if (charge_active) begin
         ovp_cnt <= ovp_cnt + 1'b1;
      end
   end

   // ****************************************************************
   // charge state machine
   // ****************************************************************
   always_comb begin
      next_state = state;
      unique case (state)
         chg_off: begin
            if (!lock) begin
               next_state = chg_wait;
            end
         end
         chg_wait: begin
            if (lock) begin
               next_state = chg_off;
            end else if (allow) begin
               next_state = chg_run;
            end
         end
         chg_run: begin
            if (lock) begin
               next_state = chg_off;
            end else if (!allow) begin
               next_state = chg_wait;
            end
         end
      endcase
   end

   assign next_run   = (next_state == chg_run);
   assign short_edge = charge_active && sense_neg_below_2v && !short_q;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state <= chg_off;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         charge_active         <= 1'b0;
         discharge_sink_enable <= 1'b0;
      end else begin
         charge_active         <= next_run;
         discharge_sink_enable <= next_run;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         regulation_mv <= `VREG_1CELL_MV;
      end else begin
         case (pack_series_select)
            series_open: regulation_mv <= `VREG_2CELL_MV;
            series_ref:  regulation_mv <= `VREG_3CELL_MV;
            default:     regulation_mv <= `VREG_1CELL_MV;
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         precharge_mode  <= 1'b1;
         current_divisor <= `PRE_DIVISOR;
      end else begin
         precharge_mode  <= !charge_rate_select;
         current_divisor <= charge_rate_select ? `FAST_DIVISOR
                                               : `PRE_DIVISOR;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         short_q             <= 1'b0;
         short_current_limit <= 1'b0;
      end else begin
         short_q             <= next_run && sense_neg_below_2v;
         short_current_limit <= next_run && sense_neg_below_2v;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         current_step <= `STEP_NONE;
         step_cnt     <= '0;
      end else if (!next_run) begin
         current_step <= `STEP_NONE;
         step_cnt     <= '0;
      end else if (!charge_rate_select) begin
         current_step <= `STEP_COUNT;
         step_cnt     <= '0;
      end else if (!charge_active || precharge_mode || short_edge) begin
         current_step <= `STEP_FIRST;
         step_cnt     <= '0;
      end else if (current_step != `STEP_COUNT) begin
         if (step_cnt == TIMER_W'(STEP_CYCLES - 1)) begin
            current_step <= current_step + `STEP_FIRST;
            step_cnt     <= '0;
         end else begin
            step_cnt <= step_cnt + 1'b1;
         end
      end
   end

   // ****************************************************************
   // switching stage
   // ****************************************************************
   // fixed period counter
   assign wrap = (pwm_cnt == PWM_LAST);

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pwm_cnt <= '0;
      end else begin
         pwm_cnt <= wrap ? 8'h00 : pwm_cnt + 8'h01;
      end
   end

   assign duty_eff = (duty > ON_MAX) ? ON_MAX : duty;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         oc_hold <= 1'b0;
      end else if (wrap) begin
         oc_hold <= 1'b0;
      end else if (high_side_overcurrent) begin
         oc_hold <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ls_block  <= 1'b0;
         refresh_q <= 1'b0;
      end else begin
         refresh_q <= next_refresh;
         if (wrap) begin
            ls_block <= 1'b0;
         end else if (refresh_q && !bootstrap_below_4v && sense_below_5mv) begin
            ls_block <= 1'b1;
         end
      end
   end

   assign next_hs = next_run && (pwm_cnt < duty_eff) && !oc_hold &&
                    !high_side_overcurrent && !charge_over_160pct &&
                    !pack_above_102pct && !short_edge;

   assign sync_ok = !sense_avg_below_1p25mv && !pack_below_2v &&
                    !sense_neg_below_2v;

   assign next_refresh = next_run && !next_hs && bootstrap_below_4v &&
                         !short_edge;
   assign next_ls = next_refresh ||
                    (next_run && !next_hs && sync_ok && !ls_block &&
                     !short_edge);

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         high_side_gate <= 1'b0;
         low_side_gate  <= 1'b0;
      end else begin
         high_side_gate <= next_hs;
         low_side_gate  <= next_ls;
      end
   end

   // ****************************************************************
   // reference and indicator
   // ****************************************************************
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         blink_cnt   <= '0;
         blink_phase <= 1'b0;
      end else if (blink_cnt == TIMER_W'(BLINK_CYCLES - 1)) begin
         blink_cnt   <= '0;
         blink_phase <= !blink_phase;
      end else begin
         blink_cnt <= blink_cnt + 1'b1;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         reference_enable <= 1'b0;
         indicator_out    <= 1'b0;
         indicator_oe     <= 1'b0;
      end else begin
         reference_enable <= !lock;
         indicator_out    <= 1'b0;
         if (lock) begin
            indicator_oe <= 1'b0;
         end else if (next_run) begin
            indicator_oe <= 1'b1;
         end else if (input_overvoltage || ovp_lat) begin
            indicator_oe <= blink_phase;
         end else begin
            indicator_oe <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // ahb-lite register slave
   // ****************************************************************
   assign addr_ok = hsel && hready && htrans[1];
   assign status  = {16'h0000, current_step, 1'b0, pack_series_select,
                     pu_done, short_current_limit, ovp_lat, ts_fault,
                     die_hot, setpoint_en, state == chg_wait,
                     precharge_mode, charge_active};

   always_comb begin
      next_permit = ctrl_permit;
      next_duty   = duty;
      if (wr_pend && wr_addr == `REG_CONTROL) begin
         next_permit = hwdata[0];
      end
      if (wr_pend && wr_addr == `REG_DUTY) begin
         next_duty = hwdata[7:0];
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         wr_pend     <= 1'b0;
         wr_addr     <= '0;
         ctrl_permit <= `CONTROL_RESET;
         duty        <= `DUTY_RESET;
      end else begin
         wr_pend     <= addr_ok && hwrite;
         wr_addr     <= haddr[3:0];
         ctrl_permit <= next_permit;
         duty        <= next_duty;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         hrdata    <= '0;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         if (addr_ok && !hwrite) begin
            case (haddr[3:0])
               `REG_CONTROL: hrdata <= {31'h0, next_permit};
               `REG_DUTY:    hrdata <= {24'h0, next_duty};
               `REG_STATUS:  hrdata <= status;
               default:      hrdata <= '0;
            endcase
         end
      end
   end

   // ****************************************************************
   // assertions
   // ****************************************************************
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         hs_run <= '0;
      end else begin
         hs_run <= high_side_gate ? hs_run + 8'h01 : 8'h00;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   a_lockout_off: assert property (
      undervoltage_lockout |=> !high_side_gate && !charge_active)
      else $error("switching during lockout");
   a_duty_cap: assert property (
      hs_run <= ON_MAX)
      else $error("high side on beyond duty cap");
   a_oc_hold: assert property (
      high_side_overcurrent && pwm_cnt < PWM_LAST - 8'h01
      |=> !high_side_gate [*2])
      else $error("high side on after overcurrent");
   a_limit_cut: assert property (
      charge_over_160pct |=> !high_side_gate)
      else $error("high side on above current limit");
   a_ovp_inhibit: assert property (
      pack_above_102pct |=> !high_side_gate)
      else $error("high side on during overvoltage");
   a_sink_track: assert property (
      discharge_sink_enable |-> state == chg_run)
      else $error("sink not tracking charge");
   a_idle_outputs: assert property (
      !supply_above_sense_neg |=> !reference_enable && !indicator_oe)
      else $error("reference or indicator active while idle");
   a_nonsync_low: assert property (
      (sense_avg_below_1p25mv || pack_below_2v) && !bootstrap_below_4v
      |=> !low_side_gate)
      else $error("low side on in non-synchronous mode");
   a_no_overlap: assert property (
      !(high_side_gate && low_side_gate))
      else $error("both switches on");
   a_step_first: assert property (
      $rose(charge_active && !precharge_mode) |-> current_step == `STEP_FIRST)
      else $error("soft start did not begin at first step");
   a_short_stop: assert property (
      short_edge |=> !high_side_gate && !low_side_gate)
      else $error("no shutdown on pack short");
   a_period_len: assert property (
      wrap |=> pwm_cnt == 8'h00 ##(PWM_PERIOD - 1) wrap)
      else $error("switching period wrong");

endmodule
`default_nettype wire

// >>> core/charger_pkg.sv
// types shared by the charger sequencer
// assumes charger_cfg.svh supplies the numeric constants
package charger_pkg;

   typedef enum logic [2:0] {
      chg_off  = 3'b001,
      chg_wait = 3'b010,
      chg_run  = 3'b100
   } charge_state_type;

   typedef enum logic [1:0] {
      series_low  = 2'h0,
      series_open = 2'h1,
      series_ref  = 2'h2
   } series_code_type;

endpackage

// >>> test/charger_control_sequencer_bench.sv
// self-checking bench for the charger sequencer
// assumes shortened timers and the pack model on the gates
`timescale 1ns/1ps
`default_nettype none
module charger_control_sequencer_bench;
   logic sys_clk=0, rst=1, hwrite=0, charge_rate_select=1, full_cmd=0;
   logic hsel=1, die_overheat_trip, die_below_130c, short_cmd=0;
   logic high_side_overcurrent=0, charge_over_160pct=0;
   logic [5:0] flt=0;
   logic [1:0] htrans=0, pack_series_select=0;
   logic [31:0] haddr=0, hwdata=0, q;
   logic [13:0] vreg [4] = '{14'h1068, 14'h20D0, 14'h3138, 14'h1068};
   int sp=200, die=25, fails=0, check_count=0, n;
   wire logic [31:0] hrdata;
   wire logic [13:0] regulation_mv;
   wire logic [6:0] current_divisor;
   wire logic [3:0] current_step;
   wire logic hreadyout, hresp, high_side_gate, low_side_gate, charge_active;
   wire logic precharge_mode, short_current_limit, discharge_sink_enable;
   wire logic reference_enable, indicator_out, indicator_oe, pack_below_2v;
   wire logic sense_neg_below_2v, pack_above_102pct, sense_avg_below_1p25mv;
   wire logic sense_below_5mv, bootstrap_below_4v;
   always #4 sys_clk = ~sys_clk;
   assign die_overheat_trip = die > 150;
   assign die_below_130c = die < 130;
   charger_control_sequencer #(.POWERUP_CYCLES(50), .STEP_CYCLES(10),
      .OVP_CYCLES(20), .BLINK_CYCLES(8)) charger_control_sequencer_i (
      .sys_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
      .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
      .pack_series_select, .charge_rate_select,
      .setpoint_above_120mv(sp > 120), .setpoint_below_40mv(sp < 40),
      .supply_above_sense_neg(!flt[3]), .undervoltage_lockout(flt[0]),
      .input_overvoltage(flt[1]), .regulators_ok(!flt[5]),
      .regulator_overload(flt[2]), .die_overheat_trip, .die_below_130c,
      .thermistor_in_start_window(!flt[4]), .thermistor_in_run_window(!flt[4]),
      .bootstrap_below_4v, .sense_below_5mv, .sense_avg_below_1p25mv,
      .pack_below_2v, .sense_neg_below_2v, .high_side_overcurrent,
      .charge_over_160pct, .pack_above_102pct, .high_side_gate, .low_side_gate,
      .charge_active, .precharge_mode, .current_divisor, .current_step,
      .regulation_mv, .short_current_limit, .discharge_sink_enable,
      .reference_enable, .indicator_out, .indicator_oe);
   pack_model pack_model_i (.sys_clk, .rst, .high_side_gate, .low_side_gate,
      .short_cmd, .full_cmd, .pack_below_2v, .sense_neg_below_2v,
      .pack_above_102pct, .sense_avg_below_1p25mv, .sense_below_5mv,
      .bootstrap_below_4v);
   // ************************************************************
   // tasks
   // ************************************************************
   task results;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      for (int k = 0; k < 2; k++) begin
         n = 0;
         do begin
            @(posedge sys_clk);
            n++;
         end while (hreadyout !== 1'b1 && n < 50);
         if (n >= 50) begin
            fails++;
            results;
         end
         if (k == 0) begin
            htrans <= 2'h0;
            hwdata <= d;
         end
      end
      q = hrdata;
   endtask
   task wait_act(input logic v);
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (charge_active !== v && n < 300);
      if (n >= 300) begin
         fails++;
         results;
      end
   endtask
   task high_count(input logic [31:0] exp);
      repeat (210) @(posedge sys_clk);
      n = 0;
      repeat (208) begin
         @(posedge sys_clk);
         n += high_side_gate;
      end
      chk(n, exp);
   endtask
   // ************************************************************
   // tests
   // ************************************************************
   initial begin
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
      ahb(0, 32'h0, 32'h0); chk(q, 32'h1);
      ahb(0, 32'hC, 32'h0); chk(q, 32'h0);
      ahb(1, 32'h4, 32'h64);
      ahb(0, 32'h4, 32'h0); chk(q, 32'h64);
      hsel <= 1'b0;
      ahb(1, 32'h4, 32'h33);
      hsel <= 1'b1;
      ahb(0, 32'h4, 32'h0); chk(q, 32'h64);
      $display("registers done");
      for (int i = 0; i < 4; i++) begin
         pack_series_select <= i[1:0];
         repeat (2) @(posedge sys_clk);
         chk(regulation_mv, vreg[i]);
      end
      ahb(0, 32'h8, 32'h0); chk(q, 32'h60C);
      charge_rate_select <= 1'b0;
      repeat (3) @(posedge sys_clk);
      chk({precharge_mode, current_divisor}, 8'hE4);
      charge_rate_select <= 1'b1;
      repeat (3) @(posedge sys_clk);
      chk({precharge_mode, current_divisor}, 8'h14);
      wait_act(1);
      chk(current_step, 4'h1);
      repeat (65) @(posedge sys_clk);
      chk(current_step, 4'h7);
      repeat (10) @(posedge sys_clk);
      chk({discharge_sink_enable, current_step}, 5'h18);
      high_count(32'd100);
      ahb(1, 32'h4, 32'hFF);
      high_count(32'd201);
      charge_over_160pct <= 1'b1;
      high_count(32'd0);
      charge_over_160pct <= 1'b0;
      high_side_overcurrent <= 1'b1;
      high_count(32'd0);
      high_side_overcurrent <= 1'b0;
      $display("gate drive done");
      full_cmd <= 1'b1;
      repeat (40) @(posedge sys_clk);
      chk({high_side_gate, charge_active}, 2'h0);
      n = 0;
      repeat (16) begin
         @(posedge sys_clk);
         n += indicator_oe;
      end
      chk(n, 32'd8);
      full_cmd <= 1'b0;
      wait_act(1);
      chk({indicator_oe, indicator_out}, 2'h2);
      short_cmd <= 1'b1;
      repeat (3) @(posedge sys_clk);
      chk({short_current_limit, current_step}, 5'h11);
      short_cmd <= 1'b0;
      sp <= 80;
      repeat (5) @(posedge sys_clk);
      chk(charge_active, 1'b1);
      sp <= 30;
      wait_act(0);
      sp <= 80;
      repeat (10) @(posedge sys_clk);
      chk(charge_active, 1'b0);
      sp <= 200;
      wait_act(1);
      die <= 160;
      wait_act(0);
      die <= 140;
      repeat (10) @(posedge sys_clk);
      chk(charge_active, 1'b0);
      die <= 25;
      wait_act(1);
      for (int i = 0; i < 6; i++) begin
         flt <= 6'h01 << i;
         wait_act(0);
         repeat (3) @(posedge sys_clk);
         if (i == 3) chk({reference_enable, indicator_oe}, 2'h0);
         flt <= 6'h00;
         wait_act(1);
      end
      $display("protection done");
      results;
   end
endmodule
`default_nettype wire

// >>> test/pack_model.sv
// pack and buck power stage seen through the sequencer's comparators
// assumes gates sampled on sys_clk and fault commands from the bench
`timescale 1ns/1ps
`default_nettype none
module pack_model (
   input  wire logic sys_clk,
   input  wire logic rst,
   input  wire logic high_side_gate,
   input  wire logic low_side_gate,
   input  wire logic short_cmd,
   input  wire logic full_cmd,
   output logic      pack_below_2v,
   output logic      sense_neg_below_2v,
   output logic      pack_above_102pct,
   output logic      sense_avg_below_1p25mv,
   output logic      sense_below_5mv,
   output logic      bootstrap_below_4v
);
   logic [9:0] level;
   logic [9:0] boot_age;
   // pack charges only while the high side conducts
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst)
         level <= 10'h000;
      else if (short_cmd)
         level <= 10'h000;
      else if (high_side_gate && level != 10'h3FF)
         level <= level + 10'h001;
   end
   // bootstrap drains unless the low side refreshes it
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst || low_side_gate)
         boot_age <= 10'h000;
      else if (boot_age != 10'h3FF)
         boot_age <= boot_age + 10'h001;
   end
   assign pack_below_2v          = level < 10'h010;
   assign sense_neg_below_2v     = short_cmd;
   assign pack_above_102pct      = full_cmd;
   assign sense_avg_below_1p25mv = !high_side_gate;
   assign sense_below_5mv        = !high_side_gate;
   assign bootstrap_below_4v     = boot_age > 10'h200;
endmodule
`default_nettype wire
